// ==== rtl/bgh_pkg.sv ====
// ==========================================================
// Contract
// - Grant follows a request by 1.5 to 3.5 clock periods.
// - Request dropped without acknowledge drops grant within 1.5 to 3.5 periods.
// - Acknowledge asserted drops grant within 1.5 to 3.5 periods.
// - Request withdrawn before acknowledge: drop grant, take bus back.
// - Strobes and read/write driven no sooner than 1.5 periods after acknowledge drops.
// - Function codes and peripheral valid driven no sooner than 1 period after acknowledge drops.
// - Strobes and read/write wait 1.5 periods after withdrawn request.
// - Function codes and peripheral valid wait 1 period after withdrawn request.
// - Asynchronous inputs are sampled and recognised on a sampling edge.
package bgh_pkg;
  // Clock rate and times in half processor periods
  localparam int CLK_NS = 10;
  localparam int PROC_PERIOD_NS = 100;
  localparam int HALF_NS = PROC_PERIOD_NS / 2;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  // Grant delay 1.5 periods, release waits
  localparam logic [3:0] GRANT_HALVES = 4'h3;
  localparam logic [3:0] NEG_HALVES = 4'h3;
  localparam logic [3:0] STRB_HALVES = 4'h3;
  localparam logic [3:0] FC_HALVES = 4'h2;
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC);
  typedef enum logic [2:0] {BGH_OWN, BGH_REQ, BGH_GRANT, BGH_FLOAT, BGH_RET} bgh_state_t;
endpackage : bgh_pkg

// ==== rtl/bgh_sync.sv ====
`timescale 1ns/1ns
module bgh_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } bgh_sync_t;
  bgh_sync_t st_reg, st_next;
  always_comb
  begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '{s1: 1'b0, s2: 1'b0};
    else
      st_reg <= st_next;
  end
  assign q = st_reg.s2;
endmodule : bgh_sync

// ==== rtl/bgh_arbiter.sv ====
`timescale 1ns/1ns
module bgh_arbiter
  import bgh_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Arbitration pins, active high inside
  input wire logic REQUEST_LINE,
  input wire logic GRANT_ACK_LINE,
  output logic GRANT_LINE,
  // Own bus cycle status
  input wire logic ADDR_STROBE_ACTIVE,
  // Drive enables for bus groups, and bus ownership flag
  output logic STRB_RW_OE,
  output logic FC_VPA_OE,
  output logic ADDR_DATA_OE,
  output logic BUS_OWNED
);
  // ==========================================================
  // Input synchronisers
  logic req_s, ack_s;
  bgh_sync u_req (.clk(CLK_SYS), .rst_n(RESETN), .d(REQUEST_LINE), .q(req_s));
  bgh_sync u_ack (.clk(CLK_SYS), .rst_n(RESETN), .d(GRANT_ACK_LINE), .q(ack_s));

  // ==========================================================
  // State
  typedef struct packed {
    bgh_state_t st;
    logic [7:0] tick;
    logic [3:0] halves;
    logic grant;
    logic strb_oe;
    logic fc_oe;
    logic ad_oe;
    logic owned;
    logic drop_armed;
  } bgh_arb_t;
  bgh_arb_t r_reg, r_next;
  logic half_tick;
  assign half_tick = (r_reg.tick == HALF_CNT - 8'h01);

  always_comb
  begin
    r_next = r_reg;
    r_next.tick = half_tick ? 8'h00 : r_reg.tick + 8'h01;
    if (half_tick && r_reg.halves != 4'h0)
      r_next.halves = r_reg.halves - 4'h1;
    unique case (r_reg.st)
      BGH_OWN:
      begin
        if (req_s && !ack_s)
        begin
          r_next.st = BGH_REQ;
          r_next.halves = GRANT_HALVES;
        end
      end
      BGH_REQ:
      begin
        if (!req_s)
          r_next.st = BGH_OWN;
        else if (r_reg.halves == 4'h0)
        begin
          r_next.grant = 1'b1;
          r_next.owned = 1'b0;
          r_next.st = BGH_GRANT;
          r_next.halves = NEG_HALVES;
        end
      end
      BGH_GRANT:
      begin
        if (!ADDR_STROBE_ACTIVE)
        begin
          r_next.strb_oe = 1'b0;
          r_next.fc_oe = 1'b0;
          r_next.ad_oe = 1'b0;
        end
        // drop grant 1.5 periods after cause
        if (!r_reg.drop_armed)
        begin
          // Hold the count until acknowledge or withdrawal starts it
          r_next.halves = NEG_HALVES;
          if (ack_s || !req_s)
            r_next.drop_armed = 1'b1;
        end
        else if (r_reg.halves == 4'h0)
        begin
          r_next.grant = 1'b0;
          r_next.drop_armed = 1'b0;
          // Bus never floated: the own cycle simply carries on
          if (r_next.strb_oe)
          begin
            r_next.owned = 1'b1;
            r_next.st = BGH_OWN;
          end
          else
            r_next.st = BGH_FLOAT;
        end
      end
      BGH_FLOAT:
      begin
        r_next.strb_oe = 1'b0;
        r_next.fc_oe = 1'b0;
        r_next.ad_oe = 1'b0;
        // acknowledge dropped: start the strobe wait to take the bus back
        if (!ack_s)
        begin
          r_next.st = BGH_RET;
          r_next.halves = STRB_HALVES;
        end
      end
      BGH_RET:
      begin
        // codes after 1 period
        // Acknowledge back again: give the codes up once more
        if (ack_s)
        begin
          r_next.fc_oe = 1'b0;
          r_next.st = BGH_FLOAT;
        end
        else
        begin
          if (r_reg.halves <= STRB_HALVES - FC_HALVES)
            r_next.fc_oe = 1'b1;
          if (r_reg.halves == 4'h0)
          begin
            r_next.strb_oe = 1'b1;
            r_next.ad_oe = 1'b1;
            r_next.owned = 1'b1;
            r_next.st = BGH_OWN;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      r_reg <= '{st: BGH_OWN, tick: 8'h00, halves: 4'h0, grant: 1'b0, strb_oe: 1'b1,
                 fc_oe: 1'b1, ad_oe: 1'b1, owned: 1'b1, drop_armed: 1'b0};
    else
      r_reg <= r_next;
  end

  assign GRANT_LINE = r_reg.grant;
  assign STRB_RW_OE = r_reg.strb_oe;
  assign FC_VPA_OE = r_reg.fc_oe;
  assign ADDR_DATA_OE = r_reg.ad_oe;
  assign BUS_OWNED = r_reg.owned;

  // ==========================================================
  // Checks
  // Pin to counting state takes two sync stages and one state edge
  localparam int SYNC_LAG = 3;
  localparam int GRANT_MIN_CYC = int'(GRANT_HALVES) * HALF_CYC - SYNC_LAG;
  localparam int NEG_MIN_CYC = int'(NEG_HALVES) * HALF_CYC - SYNC_LAG;
  localparam int STRB_MIN_CYC = int'(STRB_HALVES) * HALF_CYC - SYNC_LAG;
  localparam int FC_MIN_CYC = int'(FC_HALVES) * HALF_CYC - SYNC_LAG;
  property p_grant_min;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.grant) |-> r_reg.halves == NEG_HALVES && $past(r_reg.st) == BGH_REQ;
  endproperty
  a_grant_min: assert property (p_grant_min) else $error("grant too early");
  property p_grant_early;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.grant) |-> $past(r_reg.st, GRANT_MIN_CYC) == BGH_REQ;
  endproperty
  a_grant_early: assert property (p_grant_early) else $error("grant before request wait");
  property p_grant_late;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == BGH_REQ) [*8] ##1 (r_reg.st == BGH_REQ) [*8] |=> r_reg.st != BGH_REQ;
  endproperty
  a_grant_late: assert property (p_grant_late) else $error("grant too late");
  property p_grant_drop;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $fell(r_reg.grant) |-> r_reg.st == (r_reg.strb_oe ? BGH_OWN : BGH_FLOAT);
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant dropped in wrong state");
  property p_drop_early;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $fell(r_reg.grant) |-> $past(r_reg.drop_armed, NEG_MIN_CYC);
  endproperty
  a_drop_early: assert property (p_drop_early) else $error("grant dropped too early");
  property p_drop_late;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.grant && r_reg.drop_armed) [*8] ##1 (r_reg.grant && r_reg.drop_armed) [*8] |=> !r_reg.grant;
  endproperty
  a_drop_late: assert property (p_drop_late) else $error("grant dropped too late");
  property p_withdraw;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == BGH_REQ && !req_s) |=> r_reg.st == BGH_OWN && !r_reg.grant;
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("withdrawn request not honoured");
  property p_float;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (r_reg.st == BGH_FLOAT) |-> !r_reg.strb_oe && !r_reg.fc_oe && !r_reg.ad_oe;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while granted");
  property p_strb_wait;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.strb_oe) |-> $past(r_reg.st) == BGH_RET && $past(r_reg.halves) == 4'h0;
  endproperty
  a_strb_wait: assert property (p_strb_wait) else $error("strobes driven too soon");
  property p_fc_wait;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.fc_oe) |-> $past(r_reg.st) == BGH_RET && $past(r_reg.halves) <= 4'h1;
  endproperty
  a_fc_wait: assert property (p_fc_wait) else $error("codes driven too soon");
  property p_ack_no_own;
    @(posedge CLK_SYS) disable iff (!RESETN)
      ack_s && r_reg.st == BGH_FLOAT |=> !r_reg.owned;
  endproperty
  a_ack_no_own: assert property (p_ack_no_own) else $error("bus taken while acknowledged");
  property p_fc_before_strb;
    @(posedge CLK_SYS) disable iff (!RESETN)
      r_reg.strb_oe |-> r_reg.fc_oe;
  endproperty
  a_fc_before_strb: assert property (p_fc_before_strb) else $error("strobes before codes");
  property p_strb_gap;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.strb_oe) |-> $past(r_reg.st, STRB_MIN_CYC) == BGH_RET;
  endproperty
  a_strb_gap: assert property (p_strb_gap) else $error("strobes back before wait");
  property p_fc_gap;
    @(posedge CLK_SYS) disable iff (!RESETN)
      $rose(r_reg.fc_oe) |-> $past(r_reg.st, FC_MIN_CYC) == BGH_RET;
  endproperty
  a_fc_gap: assert property (p_fc_gap) else $error("codes back before wait");
endmodule : bgh_arbiter

// ==== bench/bgh_master.sv ====
`timescale 1ns/1ns
// ==========
// Far-side bus master
module bgh_master (
  // Clock
  input wire logic clk,
  // Arbitration
  output logic req,
  output logic ack
);
  initial
  begin
    req = 1'b0;
    ack = 1'b0;
  end
  task automatic drive(input logic r, input logic a);
  begin
    @(posedge clk);
    #1;
    req = r;
    ack = a;
  end
  endtask : drive
  task automatic take();
  begin
    drive(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    drive(1'b0, 1'b1);
  end
  endtask : take
endmodule : bgh_master

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stb = 1'b0;
  logic req, ack, gnt, s_oe, f_oe, a_oe, own;
  int miscompares = 0;
  int total_checks = 0;
  int ng, nf, ns;
  always #5 clk = ~clk;
  bgh_arbiter uut (.CLK_SYS(clk), .RESETN(rst_n), .REQUEST_LINE(req),
    .GRANT_ACK_LINE(ack), .GRANT_LINE(gnt), .ADDR_STROBE_ACTIVE(stb),
    .STRB_RW_OE(s_oe), .FC_VPA_OE(f_oe), .ADDR_DATA_OE(a_oe), .BUS_OWNED(own));
  bgh_master m (.clk(clk), .req(req), .ack(ack));
  // ==========
  // Checks
  task automatic chk(input logic g, input logic e);
  begin
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask : chk
  task automatic rng(input int g, input int lo, input int hi);
  begin
    total_checks++;
    if (g < lo || g > hi)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  end
  endtask : rng
  // Clocks until the chosen output reaches v, bounded
  task automatic span(input int sel, input logic v, output int n);
    logic s;
  begin
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      s = (sel == 0) ? gnt : (sel == 1) ? f_oe : s_oe;
    end while (s !== v && n < 60);
  end
  endtask : span
  task automatic back(input int lf, input int ls);
  begin
    fork
      span(0, 1'b0, ng);
      span(1, 1'b1, nf);
      span(2, 1'b1, ns);
    join
    // A span that hits its limit of 60 counts as a hang
    rng(nf, lf, 59);
    rng(ns, ls, 59);
    chk(own, 1'b1);
  end
  endtask : back
  // ==========
  // Scenarios
  task automatic t_ack();
  begin
    stb = 1'b1;
    m.drive(1'b1, 1'b0);
    span(0, 1'b1, ng);
    rng(ng, 15, 35);
    chk(a_oe, 1'b1);
    stb = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(a_oe, 1'b0);
    fork
      m.take();
      begin
        // Count from the edge that raises acknowledge
        @(posedge clk);
        #1;
        span(0, 1'b0, ng);
      end
    join
    rng(ng, 15, 35);
    m.drive(1'b0, 1'b0);
    back(10, 15);
    $display("test ack done");
  end
  endtask : t_ack
  task automatic t_wd();
  begin
    m.drive(1'b1, 1'b0);
    span(0, 1'b1, ng);
    rng(ng, 15, 35);
    repeat (3) @(posedge clk);
    #1;
    chk(s_oe, 1'b0);
    m.drive(1'b0, 1'b0);
    back(10, 15);
    rng(ng, 15, 35);
    $display("test withdraw done");
  end
  endtask : t_wd
  task automatic t_early();
  begin
    m.drive(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    m.drive(1'b0, 1'b0);
    // Grant must never show: the span runs into its limit
    span(0, 1'b1, ng);
    rng(ng, 60, 60);
    chk(own, 1'b1);
    chk(s_oe, 1'b1);
    $display("test early withdraw done");
  end
  endtask : t_early
  task automatic results();
  begin
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : results
  initial
  begin
    #20000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(gnt, 1'b0);
    t_ack();
    t_wd();
    t_early();
    results();
  end
endmodule : tb
